// file: pkg/iq_pkg.sv
package iq_pkg;
  // ==========================================================
  // Serial word layout
  localparam int WORD_W = 16;
  localparam int AMP_W = 8;
  localparam int ANG_W = 6;
  localparam int MAG_W = 6;
  localparam int SUM_W = MAG_W + 1;
  localparam int LEVEL_W = AMP_W + SUM_W;
  localparam int CNT_W = 5;
  localparam int CMD_HI = 15;
  localparam int CMD_LO = 14;
  localparam int AMP_MSB = 13;
  localparam int AMP_LSB = 6;
  localparam int ANG_MSB = 5;
  localparam int ANG_LSB = 0;
  localparam logic [CNT_W-1:0] FRAME_BITS = 5'h10;
  localparam logic [CNT_W-1:0] CNT_MAX = 5'h1F;

  // ==========================================================
  // Commands and angle limits
  localparam logic [1:0] CMD_WRITE = 2'h0;
  localparam logic [1:0] CMD_READ = 2'h1;
  localparam logic [1:0] CMD_PDOWN = 2'h2;
  localparam logic [1:0] CMD_NOP = 2'h3;
  localparam logic [ANG_W-1:0] ANG_FULL = 6'h30;
  localparam logic [ANG_W-1:0] ANG_QUAD = 6'h0C;
  localparam logic [AMP_W-1:0] AMP_RST = 8'h00;
  localparam logic [ANG_W-1:0] ANG_RST = 6'h00;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCK_PERIOD_NS = 800;
  localparam int SCK_HALF_CYC = SCK_PERIOD_NS / 2 / CLK_PERIOD_NS;
  localparam int LD_GAP_NS = 10;
  localparam int LD_GAP_RAW = (LD_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LD_GAP_CYC = (LD_GAP_RAW < 1) ? 1 : LD_GAP_RAW;

  // ==========================================================
  // Host controller registers (APB byte offsets)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TXWORD = 8'h04;
  localparam logic [7:0] REG_RXWORD = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam int CTRL_START = 0;
  localparam int CTRL_LOAD = 1;
  localparam int CTRL_EN = 2;
  localparam int CTRL_GATE_LSB = 4;
  localparam int STAT_BUSY = 0;
  localparam logic [4:0] CTRL_RST = 5'h00;
endpackage

// file: pkg/iq_link_if.sv
`timescale 1ns/1ps
interface iq_link_if;
  logic cs_n;
  logic sck;
  logic sdi;
  logic sdo;
  logic ld;
  logic en;
  logic ia;
  logic ib;
  logic qa;
  logic qb;
  modport dev (input cs_n, input sck, input sdi, output sdo, input ld,
               input en, input ia, input ib, input qa, input qb);
  modport host (output cs_n, output sck, output sdi, input sdo, output ld,
                output en, output ia, output ib, output qa, output qb);
endinterface

// file: rtl/iq_device.sv
// Overview of operation
// - Word: command, eight amplitude, six angle bits
// - Command 00 writes, 01 reads, 11 idles
// - Command 10 at frame end powers down
// - Chip select low; rise stores shifted word of a write frame
// - Load strobe rise copies amplitude to working
// - Serial output changes only on clock falls
// - Amplitude is unsigned code zero to 255
// - Angle counts in 7.5 degree steps
// - Host avoids angle codes above 48
// - Angle maps to signed cosine and sine
// - Level is amplitude times 63 times trig
// - Positive part to A, negative to B
// - Components add only while gates are high
// - In-phase gates drive in-phase component
// - Quadrature gates drive quadrature component
// - Enable low turns both outputs off
// - Host holds data across sampling rise
// - Load strobe rises after chip select
`timescale 1ns/1ps
module iq_device (
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // Serial link and gates
  iq_link_if.dev LINK,
  // Sink outputs
  output logic [iq_pkg::LEVEL_W-1:0] SINK_A_LEVEL,
  output logic SINK_A_OE,
  output logic [iq_pkg::LEVEL_W-1:0] SINK_B_LEVEL,
  output logic SINK_B_OE,
  // Status
  output logic [iq_pkg::AMP_W-1:0] AMP_CODE,
  output logic [iq_pkg::ANG_W-1:0] VECTOR_ANGLE,
  output logic POWER_DOWN
);
  import iq_pkg::*;

  localparam int NPIN = 9;
  // Idle pin levels: select high, all else low, so reset leaves no false edge or enable
  localparam logic [NPIN-1:0] PIN_IDLE = 9'h100;

  // ==========================================================
  // Pin synchronisers
  logic [NPIN-1:0] pins_raw;
  logic [NPIN-1:0] meta_q;
  logic [NPIN-1:0] sync_q;
  logic [NPIN-1:0] prev_q;

  assign pins_raw = {LINK.cs_n, LINK.sck, LINK.sdi, LINK.ld, LINK.en,
                     LINK.ia, LINK.ib, LINK.qa, LINK.qb};

  // Two stages before use, a third only for edge finding
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      meta_q <= PIN_IDLE;
      sync_q <= PIN_IDLE;
      prev_q <= PIN_IDLE;
    end else begin
      meta_q <= pins_raw;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Named views of the synchronised pins
  logic cs_n_s;
  logic sck_s;
  logic sdi_s;
  logic ld_s;
  logic en_s;
  logic ia_s;
  logic ib_s;
  logic qa_s;
  logic qb_s;
  assign {cs_n_s, sck_s, sdi_s, ld_s, en_s, ia_s, ib_s, qa_s, qb_s} = sync_q;

  // Edge events
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic cs_fall;
  logic ld_rise;
  assign sck_rise = sck_s & ~prev_q[7] & ~cs_n_s;
  assign sck_fall = ~sck_s & prev_q[7] & ~cs_n_s;
  assign cs_rise = cs_n_s & ~prev_q[8];
  assign cs_fall = ~cs_n_s & prev_q[8];
  assign ld_rise = ld_s & ~prev_q[5];

  // ==========================================================
  // Receive shifter and frame check
  logic [WORD_W-1:0] shift_q;
  logic [WORD_W-1:0] shift_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic frame_ok;
  logic [1:0] cmd;

  // Sample on rises, command bits enter first
  assign shift_d = sck_rise ? {shift_q[WORD_W-2:0], sdi_s} : shift_q;
  assign cnt_d = cs_fall ? '0 :
                 (sck_rise && cnt_q != CNT_MAX) ? cnt_q + 5'h01 : cnt_q;
  // Exactly sixteen rises make a valid frame; others change nothing
  assign frame_ok = cs_rise && (cnt_q == FRAME_BITS);
  assign cmd = shift_q[CMD_HI:CMD_LO];

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      shift_q <= '0;
      cnt_q <= '0;
    end else begin
      shift_q <= shift_d;
      cnt_q <= cnt_d;
    end
  end

  // ==========================================================
  // Buffer, working amplitude and power state
  logic [AMP_W-1:0] buf_amp_q;
  logic [AMP_W-1:0] work_amp_q;
  logic [ANG_W-1:0] angle_q;
  logic pd_q;
  logic rd_pend_q;
  logic do_write;

  assign do_write = frame_ok && (cmd == CMD_WRITE);

  // Chip select rise stores the word; write command only
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      buf_amp_q <= AMP_RST;
      angle_q <= ANG_RST;
    end else if (do_write) begin
      buf_amp_q <= shift_q[AMP_MSB:AMP_LSB];
      angle_q <= shift_q[ANG_MSB:ANG_LSB];
    end
  end

  // Load strobe rise moves the level into effect
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      work_amp_q <= AMP_RST;
    end else if (ld_rise) begin
      work_amp_q <= buf_amp_q;
    end
  end

  // Every valid frame decides the power state; only power-down sets it, no-op clears it
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pd_q <= 1'b0;
    end else if (frame_ok) begin
      pd_q <= (cmd == CMD_PDOWN);
    end
  end

  // ==========================================================
  // Read-back shifter
  logic [WORD_W-1:0] tx_q;
  logic sdo_q;
  logic [WORD_W-1:0] rd_word;

  assign rd_word = {CMD_WRITE, work_amp_q, angle_q};

  // A read frame arms the reply; the next frame carries it out
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rd_pend_q <= 1'b0;
      tx_q <= '0;
      sdo_q <= 1'b0;
    end else begin
      if (frame_ok) begin
        rd_pend_q <= (cmd == CMD_READ);
      end else if (cs_fall) begin
        rd_pend_q <= 1'b0;
      end
      if (cs_fall) begin
        tx_q <= rd_pend_q ? rd_word : '0;
      end else if (sck_fall) begin
        sdo_q <= tx_q[WORD_W-1];
        tx_q <= {tx_q[WORD_W-2:0], 1'b0};
      end
    end
  end

  assign LINK.sdo = sdo_q;

  // ==========================================================
  // Angle to cosine and sine
  // Magnitude of 63*sin(k*7.5 deg), k from 0 to 12
  function automatic logic [MAG_W-1:0] sin_mag(input logic [3:0] k);
    logic [MAG_W-1:0] m;
    m = 6'h00;
    case (k)
      4'h0: m = 6'h00;
      4'h1: m = 6'h08;
      4'h2: m = 6'h10;
      4'h3: m = 6'h18;
      4'h4: m = 6'h20;
      4'h5: m = 6'h26;
      4'h6: m = 6'h2D;
      4'h7: m = 6'h32;
      4'h8: m = 6'h37;
      4'h9: m = 6'h3A;
      4'hA: m = 6'h3D;
      4'hB: m = 6'h3E;
      4'hC: m = 6'h3F;
      default: m = 6'h00;
    endcase
    return m;
  endfunction

  logic [ANG_W-1:0] eff_ang;
  logic [1:0] quad;
  logic [ANG_W-1:0] quad_base;
  logic [ANG_W-1:0] rem6;
  logic [3:0] rem;
  logic [3:0] rem_c;
  logic [MAG_W-1:0] cos_mag;
  logic [MAG_W-1:0] sin_mag_v;
  logic cos_neg;
  logic sin_neg;

  // 48 is a full turn; reserved codes above it also fall back to zero
  assign eff_ang = (angle_q >= ANG_FULL) ? ANG_RST : angle_q;
  assign quad = (eff_ang < ANG_QUAD) ? 2'h0 :
                (eff_ang < 6'h18) ? 2'h1 :
                (eff_ang < 6'h24) ? 2'h2 : 2'h3;
  assign quad_base = {1'b0, quad, 3'h0} + {2'h0, quad, 2'h0};
  assign rem6 = eff_ang - quad_base;
  assign rem = rem6[3:0];
  assign rem_c = 4'hC - rem;
  // Quadrant picks which table index feeds each axis and its sign
  assign cos_mag = quad[0] ? sin_mag(rem) : sin_mag(rem_c);
  assign sin_mag_v = quad[0] ? sin_mag(rem_c) : sin_mag(rem);
  assign cos_neg = (quad == 2'h1) || (quad == 2'h2);
  assign sin_neg = quad[1];

  // ==========================================================
  // Gated channel sums and scaling
  logic [MAG_W-1:0] a_i;
  logic [MAG_W-1:0] a_q;
  logic [MAG_W-1:0] b_i;
  logic [MAG_W-1:0] b_q;
  logic [SUM_W-1:0] a_sum;
  logic [SUM_W-1:0] b_sum;
  logic [LEVEL_W-1:0] a_level;
  logic [LEVEL_W-1:0] b_level;
  logic drive_on;

  // Sign steers to A or B; gates pass each axis separately
  assign a_i = (ia_s && !cos_neg) ? cos_mag : 6'h00;
  assign b_i = (ib_s && cos_neg) ? cos_mag : 6'h00;
  assign a_q = (qa_s && !sin_neg) ? sin_mag_v : 6'h00;
  assign b_q = (qb_s && sin_neg) ? sin_mag_v : 6'h00;
  assign a_sum = {1'b0, a_i} + {1'b0, a_q};
  assign b_sum = {1'b0, b_i} + {1'b0, b_q};
  // Unsigned code times trig; the analog offset is not modelled
  assign a_level = {7'h00, work_amp_q} * {8'h00, a_sum};
  assign b_level = {7'h00, work_amp_q} * {8'h00, b_sum};
  assign drive_on = en_s && !pd_q;

  // Outputs registered; disabled means released and zero level
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SINK_A_LEVEL <= '0;
      SINK_B_LEVEL <= '0;
      SINK_A_OE <= 1'b0;
      SINK_B_OE <= 1'b0;
    end else begin
      SINK_A_LEVEL <= drive_on ? a_level : '0;
      SINK_B_LEVEL <= drive_on ? b_level : '0;
      SINK_A_OE <= drive_on;
      SINK_B_OE <= drive_on;
    end
  end

  // Status copies
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      AMP_CODE <= AMP_RST;
      VECTOR_ANGLE <= ANG_RST;
      POWER_DOWN <= 1'b0;
    end else begin
      AMP_CODE <= work_amp_q;
      VECTOR_ANGLE <= angle_q;
      POWER_DOWN <= pd_q;
    end
  end
endmodule

// file: rtl/iq_host.sv
`timescale 1ns/1ps
module iq_host #(
  parameter int HALF_CYC = iq_pkg::SCK_HALF_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Serial link and gates
  iq_link_if.host LINK
);
  import iq_pkg::*;

  localparam int GAP_CYC = (LD_GAP_CYC > HALF_CYC) ? LD_GAP_CYC : HALF_CYC;
  localparam int TMR_W = 8;
  localparam logic [TMR_W-1:0] HALF_T = TMR_W'(HALF_CYC - 1);
  localparam logic [TMR_W-1:0] TAIL_T = TMR_W'(2 * HALF_CYC - 1);
  localparam logic [TMR_W-1:0] GAP_T = TMR_W'(GAP_CYC - 1);

  typedef enum logic [2:0] {H_IDLE, H_LEAD, H_LOW, H_HIGH, H_TAIL, H_GAP, H_LD} hstate_t;

  // ==========================================================
  // APB decode
  logic wr_en;
  logic rd_setup;
  logic hit_ctrl;
  logic hit_tx;
  logic hit_rx;
  logic hit_stat;
  logic mapped;
  logic [31:0] rd_mux;
  logic [4:0] ctrl_q;
  logic [WORD_W-1:0] txw_q;
  logic [WORD_W-1:0] rxw_q;
  logic [WORD_W-1:0] rx_sh_q;
  logic busy;
  logic start_req;
  logic ld_req_q;
  hstate_t st_q;

  assign wr_en = PSEL & PENABLE & PWRITE;
  assign rd_setup = PSEL & ~PENABLE;
  assign hit_ctrl = PADDR == REG_CTRL;
  assign hit_tx = PADDR == REG_TXWORD;
  assign hit_rx = PADDR == REG_RXWORD;
  assign hit_stat = PADDR == REG_STATUS;
  assign mapped = hit_ctrl | hit_tx | hit_rx | hit_stat;
  assign busy = st_q != H_IDLE;
  assign start_req = wr_en & hit_ctrl & PWDATA[CTRL_START] & ~busy;
  assign rd_mux = hit_ctrl ? {24'h00_0000, ctrl_q[4:1], 1'b0, ctrl_q[0], 2'h0} :
                  hit_tx ? {16'h0000, txw_q} :
                  hit_rx ? {16'h0000, rxw_q} :
                  hit_stat ? {31'h0000_0000, busy} : 32'h0000_0000;

  // Read data captured in setup, so the access phase needs no wait
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PRDATA <= '0;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= 1'b1;
      if (rd_setup) begin
        PRDATA <= rd_mux;
        PSLVERR <= ~mapped;
      end
    end
  end

  // Control and word registers
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_q <= CTRL_RST;
      txw_q <= '0;
    end else if (wr_en) begin
      if (hit_ctrl) begin
        ctrl_q <= {PWDATA[CTRL_GATE_LSB +: 4], PWDATA[CTRL_EN]};
      end
      if (hit_tx && !busy) begin
        txw_q <= PWDATA[WORD_W-1:0];
      end
    end
  end

  // ==========================================================
  // Frame sequencer
  logic [TMR_W-1:0] tmr_q;
  logic [CNT_W-1:0] bit_q;
  logic [WORD_W-1:0] out_sh_q;
  logic cs_n_q;
  logic sck_q;
  logic sdi_q;
  logic ld_q;
  logic sdo_m_q;
  logic sdo_s_q;
  logic tdone;

  assign tdone = tmr_q == '0;

  // Serial output from the device passes two stages first
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sdo_m_q <= 1'b0;
      sdo_s_q <= 1'b0;
    end else begin
      sdo_m_q <= LINK.sdo;
      sdo_s_q <= sdo_m_q;
    end
  end

  // Mode 0 timing: data set on fall, device samples on rise
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_q <= H_IDLE;
      tmr_q <= '0;
      bit_q <= '0;
      out_sh_q <= '0;
      rx_sh_q <= '0;
      rxw_q <= '0;
      cs_n_q <= 1'b1;
      sck_q <= 1'b0;
      sdi_q <= 1'b0;
      ld_q <= 1'b0;
      ld_req_q <= 1'b0;
    end else begin
      tmr_q <= tdone ? tmr_q : tmr_q - 8'h01;
      case (st_q)
        H_IDLE: begin
          if (start_req) begin
            st_q <= H_LEAD;
            ld_req_q <= PWDATA[CTRL_LOAD];
            cs_n_q <= 1'b0;
            sdi_q <= txw_q[WORD_W-1];
            out_sh_q <= {txw_q[WORD_W-2:0], 1'b0};
            bit_q <= '0;
            tmr_q <= HALF_T;
          end else if (wr_en && hit_ctrl && PWDATA[CTRL_LOAD]) begin
            st_q <= H_LD;
            ld_q <= 1'b1;
            tmr_q <= HALF_T;
          end
        end
        H_LEAD, H_LOW: begin
          if (tdone) begin
            st_q <= H_HIGH;
            sck_q <= 1'b1;
            bit_q <= bit_q + 5'h01;
            tmr_q <= HALF_T;
          end
        end
        H_HIGH: begin
          if (tdone) begin
            sck_q <= 1'b0;
            rx_sh_q <= {rx_sh_q[WORD_W-2:0], sdo_s_q};
            tmr_q <= (bit_q == FRAME_BITS) ? TAIL_T : HALF_T;
            st_q <= (bit_q == FRAME_BITS) ? H_TAIL : H_LOW;
            sdi_q <= out_sh_q[WORD_W-1];
            out_sh_q <= {out_sh_q[WORD_W-2:0], 1'b0};
          end
        end
        H_TAIL: begin
          if (tdone) begin
            cs_n_q <= 1'b1;
            rxw_q <= {rx_sh_q[WORD_W-2:0], sdo_s_q};
            st_q <= H_GAP;
            tmr_q <= GAP_T;
          end
        end
        H_GAP: begin
          // Strobe rises only after chip select has been high a while
          if (tdone) begin
            st_q <= ld_req_q ? H_LD : H_IDLE;
            ld_q <= ld_req_q;
            ld_req_q <= 1'b0;
            tmr_q <= HALF_T;
          end
        end
        H_LD: begin
          if (tdone) begin
            ld_q <= 1'b0;
            st_q <= H_IDLE;
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  assign LINK.cs_n = cs_n_q;
  assign LINK.sck = sck_q;
  assign LINK.sdi = sdi_q;
  assign LINK.ld = ld_q;
  assign LINK.en = ctrl_q[0];
  assign LINK.ia = ctrl_q[1];
  assign LINK.ib = ctrl_q[2];
  assign LINK.qa = ctrl_q[3];
  assign LINK.qb = ctrl_q[4];
endmodule

// file: tb/iq_monitor.sv
`timescale 1ns/1ps
module iq_monitor (
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // Link wires
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic ld
);
  import iq_pkg::*;
  logic sck_q;
  logic [4:0] rises_q;
  logic [4:0] rises_d;
  // Clock rises per frame; saturates so a runaway frame never wraps back to sixteen
  assign rises_d = cs_n ? 5'h00 : (sck && !sck_q && rises_q != CNT_MAX) ? rises_q + 5'h01 : rises_q;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sck_q <= 1'b0;
      rises_q <= 5'h00;
    end else begin
      sck_q <= sck;
      rises_q <= rises_d;
    end
  end
  default clocking mon_cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // ==========================================================
  // Framing and clocking on the wire
  a_frame_bit_count: assert property ($rose(cs_n) |-> rises_q == FRAME_BITS)
    else $error("frame closed without sixteen clock rises");
  a_cs_lead_time: assert property ($fell(cs_n) |-> !sck [*4] ##1 sck)
    else $error("first clock rise not four cycles after select");
  a_sck_idle_low: assert property (cs_n && $past(cs_n) |-> !sck)
    else $error("serial clock active while deselected");
  a_sck_high_time: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
    else $error("serial clock high time wrong");
  a_sdi_hold_high: assert property (sck |-> $stable(sdi))
    else $error("data in moved while clock high");
  // ==========================================================
  // Load strobe and reply timing
  a_ld_after_cs: assert property ($rose(ld) |-> cs_n && $past(cs_n))
    else $error("load strobe rose without select gap");
  a_ld_pulse_width: assert property ($rose(ld) |-> ld [*4] ##1 !ld)
    else $error("load strobe width wrong");
  // Synchroniser lag puts the change three cycles after the fall, still in the low phase
  a_sdo_on_fall: assert property ($changed(sdo) |-> !$past(sck) || !$past(sck, 2))
    else $error("data out changed after a clock rise");
  c_frame_end: cover property ($rose(cs_n));
  c_load: cover property ($rose(ld));
  c_reply: cover property ($changed(sdo) && !cs_n);
endmodule

// file: tb/test_iq_pulser_serial_control.sv
`timescale 1ns/1ps
module test_iq_pulser_serial_control;
  import iq_pkg::*;
  logic CLK, ARST_N, psel, penable, pwrite, pready, pslverr, slv, oe_a, oe_b, pdn, en_on;
  logic [7:0] paddr, a;
  logic [31:0] pwdata, prdata, rd, seed, r;
  logic [LEVEL_W-1:0] lvl_a, lvl_b;
  logic [AMP_W-1:0] amp;
  logic [ANG_W-1:0] ang, ang2;
  logic [3:0] gates;
  int k, num_errors, check_count;
  int tbl[11] = '{0, 1, 6, 12, 18, 24, 30, 36, 42, 47, 48};
  iq_link_if link();
  iq_link_if link2();
  iq_host i_iq_host (.CLK(CLK), .ARST_N(ARST_N), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .LINK(link));
  iq_device i_iq_device (.CLK(CLK), .ARST_N(ARST_N), .LINK(link), .SINK_A_LEVEL(lvl_a), .SINK_A_OE(oe_a),
    .SINK_B_LEVEL(lvl_b), .SINK_B_OE(oe_b), .AMP_CODE(amp), .VECTOR_ANGLE(ang), .POWER_DOWN(pdn));
  // Second device faces the bench directly so malformed frames can be sent
  iq_device i_iq_device2 (.CLK(CLK), .ARST_N(ARST_N), .LINK(link2), .SINK_A_LEVEL(), .SINK_A_OE(),
    .SINK_B_LEVEL(), .SINK_B_OE(), .AMP_CODE(), .VECTOR_ANGLE(ang2), .POWER_DOWN());
  iq_monitor i_iq_monitor (.CLK(CLK), .ARST_N(ARST_N), .cs_n(link.cs_n), .sck(link.sck), .sdi(link.sdi),
    .sdo(link.sdo), .ld(link.ld));
  // Clock
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  // ==========================================================
  // Expectation helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Rounded 63 times trig of the angle, zero unless its sign matches the channel
  function automatic int mag(input int n, input bit use_cos, input bit want_pos);
    real t;
    real v;
    t = n * 7.5 * 3.14159265358979 / 180.0;
    v = use_cos ? $cos(t) : $sin(t);
    if ((v > 0.0) != want_pos) return 0;
    // Small bias so exact halves (30 and 60 degrees) round up despite float error
    return int'($floor(63.0 * (v < 0.0 ? -v : v) + 0.5 + 1.0e-6));
  endfunction
  function automatic logic [LEVEL_W-1:0] exp_lvl(input int c, input int n, input bit pos, input logic gi,
    input logic gq);
    return LEVEL_W'(c * ((gi ? mag(n, 1'b1, pos) : 0) + (gq ? mag(n, 1'b0, pos) : 0)));
  endfunction
  // ==========================================================
  // Bus and link tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Holds the request until pready is seen high; zero wait states are not assumed
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge CLK);
    penable <= 1'b1;
    do begin
      @(posedge CLK);
    end while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic frame(input logic [15:0] w, input logic load);
    apb(1'b1, REG_TXWORD, {16'h0000, w});
    apb(1'b1, REG_CTRL, {24'h00_0000, gates, 1'b0, en_on, load, 1'b1});
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    // Only the watchdog ends a hung poll
    while (rd[STAT_BUSY] !== 1'b0) begin
      apb(1'b0, REG_STATUS, 32'h0000_0000);
    end
    repeat (12) @(posedge CLK);
  endtask
  // Bench as host on the second link, with n clock rises instead of sixteen
  task automatic bang(input logic [15:0] w, input int n);
    link2.cs_n <= 1'b0;
    link2.sdi <= w[15];
    for (int j = 0; j < n; j++) begin
      repeat (4) @(posedge CLK);
      link2.sck <= 1'b1;
      repeat (4) @(posedge CLK);
      link2.sck <= 1'b0;
      link2.sdi <= (j < 15) ? w[14-j] : 1'b0;
    end
    repeat (8) @(posedge CLK);
    link2.cs_n <= 1'b1;
    link2.sdi <= ~link2.sdi;
    repeat (4) @(posedge CLK);
    link2.ld <= 1'b1;
    repeat (4) @(posedge CLK);
    link2.ld <= 1'b0;
    repeat (12) @(posedge CLK);
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Watchdog; a full run needs well under a third of this
  initial begin
    repeat (20000) @(posedge CLK);
    num_errors++;
    complete_run();
  end
  // ==========================================================
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, ARST_N} = '0;
    {link2.sck, link2.sdi, link2.ld, link2.ia, link2.ib, link2.qa, link2.qb} = '0;
    link2.cs_n = 1'b1;
    link2.en = 1'b1;
    seed = 32'h0000_003A;
    en_on = 1'b1;
    num_errors = 0;
    check_count = 0;
    repeat (6) @(posedge CLK);
    ARST_N <= 1'b1;
    repeat (3) @(posedge CLK);
    apb(1'b0, REG_CTRL, 32'h0000_0000);
    check(rd, 32'(CTRL_RST));
    apb(1'b0, 8'h10, 32'h0000_0000);
    check(32'(slv), 32'h0000_0001);
    check(32'({amp, ang}), 32'({AMP_RST, ANG_RST}));
    // Angle table corners first, then random angles, amplitudes and gate patterns
    for (int i = 0; i < 14; i++) begin
      r = xs();
      k = (i < 11) ? tbl[i] : int'(r[31:16] % 49);
      a = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : r[15:8];
      gates = (i == 0) ? 4'hF : r[3:0];
      frame({CMD_WRITE, a, 6'(k)}, 1'b1);
      check(32'(amp), 32'(a));
      check(32'(ang), 32'(k));
      check(32'(lvl_a), 32'(exp_lvl(a, k, 1'b1, gates[0], gates[2])));
      check(32'(lvl_b), 32'(exp_lvl(a, k, 1'b0, gates[1], gates[3])));
      check(32'({oe_a, oe_b}), 32'h0000_0003);
    end
    frame({CMD_WRITE, ~a, 6'h03}, 1'b0);
    check(32'({amp, ang}), 32'({a, 6'h03}));
    frame({CMD_READ, 8'h00, 6'h00}, 1'b0);
    frame({CMD_NOP, 8'h00, 6'h00}, 1'b0);
    check(32'({amp, ang}), 32'({a, 6'h03}));
    apb(1'b0, REG_RXWORD, 32'h0000_0000);
    check(rd & 32'h0000_FFFF, {16'h0000, 2'b00, a, 6'h03});
    // Load strobe alone, no frame: the buffered amplitude takes effect
    apb(1'b1, REG_CTRL, {24'h00_0000, gates, 1'b0, en_on, 2'b10});
    repeat (16) @(posedge CLK);
    check({24'h00_0000, amp}, {24'h00_0000, ~a});
    frame({CMD_PDOWN, 8'h00, 6'h00}, 1'b0);
    check(32'({pdn, oe_a, oe_b}), 32'h0000_0004);
    frame({CMD_NOP, 8'h00, 6'h00}, 1'b0);
    check(32'({pdn, oe_a, oe_b}), 32'h0000_0003);
    en_on = 1'b0;
    apb(1'b1, REG_CTRL, {24'h00_0000, gates, 4'h0});
    repeat (8) @(posedge CLK);
    check(32'({oe_a, oe_b}), 32'h0000_0000);
    bang(16'h0485, 15);
    check(32'(ang2), 32'(ANG_RST));
    bang(16'h0485, 17);
    check(32'(ang2), 32'(ANG_RST));
    bang(16'h0485, 16);
    check(32'(ang2), 32'h0000_0005);
    complete_run();
  end
endmodule
